// [cmf_filter.sv]
// Acceptance mask filter: sixteen filters, three masks, APB registers.
// Assumes frame identifiers arrive synchronous to core_clk_in.
//
// Overview of operation
// - Sixteen filters each own a register with extension bits 15..0.
// - Extension bits 15..0 must equal the filter where the mask says so.
// - Three masks each have a standard part and an extension part.
// - Two-bit selectors pack filters 0-7 low word, 8-15 high word.
// - Selector 00, 01, 10 pick mask 0, 1, 2; 11 is reserved.
// - Mask standard bits 15..5 set to one join the comparison.
// - Mask bits 1..0 cover extension bits 17 and 16 the same way.
// - With the type mode bit set, frame type must equal the filter's.
// - With the type mode bit clear, either frame type may match.
// - Bits 4 and 2 of the mask standard register read zero.
// - Filter standard bits 15..5 must equal the frame's bits.
// - Filter extended-select picks extended (1) or standard (0) frames.
// - A filter takes part only while its enable bit is one.
`timescale 1ns/100ps
module cmf_filter
  import cmf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Received frames
  input wire logic frame_valid_in,
  input wire cmf_frame_s frame_in,
  // Acceptance result
  output logic accept_out,
  output logic [3:0] hit_index_out,
  output logic [15:0] hit_vec_out
);

  cmf_state_s r_q;
  cmf_state_s r_d;

  cmf_filt_s [NUM_FILT-1:0] filt;
  cmf_mask_s [NUM_MASK-1:0] masks;
  logic [31:0] sel_all;
  logic [NUM_FILT-1:0] hits;
  logic any_hit;
  logic [3:0] win_idx;
  logic setup;
  logic access;
  cmf_reg_e rsel;

  function automatic cmf_reg_e reg_decode(input logic [11:0] a);
    cmf_reg_e r;
    r = REG_NONE;
    if (a[11:6] == OFF_FILT_SID[11:6]) begin
      r = REG_FSID;
    end else if (a[11:6] == OFF_FILT_EID[11:6]) begin
      r = REG_FEID;
    end else if (a[11:4] == OFF_MASK_SID[11:4] && a[3:2] != 2'b11) begin
      r = REG_MSID;
    end else if (a[11:4] == OFF_MASK_EID[11:4] && a[3:2] != 2'b11) begin
      r = REG_MEID;
    end else if (a[11:2] == OFF_SEL_LO[11:2]) begin
      r = REG_SELL;
    end else if (a[11:2] == OFF_SEL_HI[11:2]) begin
      r = REG_SELH;
    end else if (a[11:2] == OFF_FILT_EN[11:2]) begin
      r = REG_FEN;
    end else if (a[11:2] == OFF_STATUS[11:2]) begin
      r = REG_STAT;
    end
    return r;
  endfunction

  // Byte-lane merge; bits outside impl are held at zero
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] strb,
                                       input logic [15:0] impl);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & impl;
  endfunction

  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign rsel = reg_decode(paddr_in);

  // Register fields feeding the comparators
  always_comb begin
    for (int i = 0; i < NUM_FILT; i++) begin
      filt[i].standard_identifier_bits = r_q.filt_sid[i][SID_MSB:SID_LSB];
      filt[i].filter_extended_select = r_q.filt_sid[i][TYPE_BIT];
      filt[i].extended_identifier_bits = {r_q.filt_sid[i][EIDH_MSB:0], r_q.filt_eid[i]};
    end
    for (int k = 0; k < NUM_MASK; k++) begin
      masks[k].standard_identifier_bits = r_q.mask_sid[k][SID_MSB:SID_LSB];
      masks[k].frame_type_match_mode = r_q.mask_sid[k][TYPE_BIT];
      masks[k].extended_identifier_bits = {r_q.mask_sid[k][EIDH_MSB:0], r_q.mask_eid[k]};
    end
  end

  // Filter 7 sits in the top pair of the low word
  assign sel_all = {r_q.sel_hi, r_q.sel_lo};

  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : g_flt
      cmf_match u_match (
        .filt_in(filt[g]),
        .masks_in(masks),
        .sel_in(sel_all[2*g +: 2]),
        .en_in(r_q.filt_en[g]),
        .frame_in(frame_in),
        .hit_out(hits[g])
      );
    end
  endgenerate

  cmf_prio u_prio (
    .hits_in(hits),
    .any_out(any_hit),
    .idx_out(win_idx)
  );

  always_comb begin
    r_d = r_q;
    r_d.accept = 1'b0;
    // Read data is captured in setup so it leaves a flip-flop
    if (setup) begin
      r_d.perr = (rsel == REG_NONE);
      r_d.prdata = 32'h0000_0000;
      case (rsel)
        REG_FSID: r_d.prdata[15:0] = r_q.filt_sid[paddr_in[5:2]];
        REG_FEID: r_d.prdata[15:0] = r_q.filt_eid[paddr_in[5:2]];
        REG_MSID: r_d.prdata[15:0] = r_q.mask_sid[paddr_in[3:2]];
        REG_MEID: r_d.prdata[15:0] = r_q.mask_eid[paddr_in[3:2]];
        REG_SELL: r_d.prdata[15:0] = r_q.sel_lo;
        REG_SELH: r_d.prdata[15:0] = r_q.sel_hi;
        REG_FEN: r_d.prdata[15:0] = r_q.filt_en;
        REG_STAT: begin
          r_d.prdata = {r_q.hit_vec, r_q.acc_cnt, 3'b000, r_q.last_any,
                        r_q.hit_idx};
        end
        default: r_d.prdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite_in) begin
      case (rsel)
        REG_FSID: begin
          r_d.filt_sid[paddr_in[5:2]] = wr16(r_q.filt_sid[paddr_in[5:2]],
                                             pwdata_in, pstrb_in,
                                             SID_REG_IMPL);
        end
        REG_FEID: begin
          r_d.filt_eid[paddr_in[5:2]] = wr16(r_q.filt_eid[paddr_in[5:2]],
                                             pwdata_in, pstrb_in, FULL_IMPL);
        end
        REG_MSID: begin
          // Unimplemented bits 4 and 2 stay zero
          r_d.mask_sid[paddr_in[3:2]] = wr16(r_q.mask_sid[paddr_in[3:2]],
                                             pwdata_in, pstrb_in,
                                             SID_REG_IMPL);
        end
        REG_MEID: begin
          r_d.mask_eid[paddr_in[3:2]] = wr16(r_q.mask_eid[paddr_in[3:2]],
                                             pwdata_in, pstrb_in, FULL_IMPL);
        end
        REG_SELL: begin
          r_d.sel_lo = wr16(r_q.sel_lo, pwdata_in, pstrb_in, FULL_IMPL);
        end
        REG_SELH: begin
          r_d.sel_hi = wr16(r_q.sel_hi, pwdata_in, pstrb_in, FULL_IMPL);
        end
        REG_FEN: begin
          r_d.filt_en = wr16(r_q.filt_en, pwdata_in, pstrb_in, FULL_IMPL);
        end
        default: r_d.filt_en = r_q.filt_en;
      endcase
    end
    // One acceptance decision per presented identifier
    if (frame_valid_in) begin
      r_d.accept = any_hit;
      r_d.last_any = any_hit;
      r_d.hit_idx = win_idx;
      r_d.hit_vec = hits;
      if (any_hit) begin
        r_d.acc_cnt = r_q.acc_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // Identifier registers are loaded with RST_ID (zero) on reset
      r_q.filt_sid <= {NUM_FILT{RST_ID}};
      r_q.filt_eid <= {NUM_FILT{RST_ID}};
      r_q.mask_sid <= {NUM_MASK{RST_ID}};
      r_q.mask_eid <= {NUM_MASK{RST_ID}};
      r_q.sel_lo <= RST_SEL;
      r_q.sel_hi <= RST_SEL;
      r_q.filt_en <= RST_FILT_EN;
      r_q.prdata <= 32'h0000_0000;
      r_q.perr <= 1'b0;
      r_q.accept <= 1'b0;
      r_q.last_any <= 1'b0;
      r_q.hit_idx <= 4'h0;
      r_q.hit_vec <= 16'h0000;
      r_q.acc_cnt <= 8'h00;
    end else begin
      r_q <= r_d;
    end
  end

  // Zero-wait slave: the access phase always completes at once
  assign pready_out = access;
  assign pslverr_out = access & r_q.perr;
  assign prdata_out = r_q.prdata;
  assign accept_out = r_q.accept;
  assign hit_index_out = r_q.hit_idx;
  assign hit_vec_out = r_q.hit_vec;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  logic f0_sid_eq;
  logic f0_eid_eq;
  assign f0_sid_eq = ((frame_in.standard_identifier_bits ^ filt[0].standard_identifier_bits) & masks[0].standard_identifier_bits) == 11'h000;
  assign f0_eid_eq = ((frame_in.extended_identifier_bits ^ filt[0].extended_identifier_bits) & masks[0].extended_identifier_bits)
                     == 18'h0_0000;

  // Per-filter views so every filter is checked, not only filter 0
  logic [NUM_FILT-1:0] rsvd_vec;
  logic [NUM_FILT-1:0] wrong_type;

  // Mode bit of the mask that a selector picks; reserved gives zero
  function automatic logic sel_frame_type_match_mode(input cmf_mask_s [NUM_MASK-1:0] mk,
                                    input logic [1:0] s);
    logic v;
    v = 1'b0;
    case (cmf_msel_e'(s))
      MSEL_M0: v = mk[0].frame_type_match_mode;
      MSEL_M1: v = mk[1].frame_type_match_mode;
      MSEL_M2: v = mk[2].frame_type_match_mode;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_FILT; i++) begin
      rsvd_vec[i] = (sel_all[2*i +: 2] == MSEL_RSVD);
      wrong_type[i] = sel_frame_type_match_mode(masks, sel_all[2*i +: 2]) &&
                      (frame_in.ext != filt[i].filter_extended_select);
    end
  end

  a_accept_follows: assert property (
    frame_valid_in && any_hit |=> accept_out && hit_index_out == $past(win_idx)
  ) else $error("accepted frame not reported one cycle later");

  a_disabled_silent: assert property (
    frame_valid_in && r_q.filt_en == 16'h0000 |=> !accept_out
  ) else $error("frame accepted with every filter disabled");

  a_sid_compare: assert property (
    hits[0] && sel_all[1:0] == MSEL_M0 |-> f0_sid_eq
  ) else $error("filter 0 hit with masked standard bits unequal");

  a_eid_compare: assert property (
    hits[0] && frame_in.ext && sel_all[1:0] == MSEL_M0 |-> f0_eid_eq
  ) else $error("filter 0 hit with masked extension bits unequal");

  a_type_gate: assert property (
    sel_all[1:0] == MSEL_M0 && masks[0].frame_type_match_mode &&
    frame_in.ext != filt[0].filter_extended_select |-> !hits[0]
  ) else $error("filter 0 hit on the wrong frame type");

  a_any_type: assert property (
    frame_valid_in && r_q.filt_en[0] && sel_all[1:0] == MSEL_M0 &&
    !masks[0].frame_type_match_mode && f0_sid_eq && (!frame_in.ext || f0_eid_eq)
    |=> accept_out && hit_vec_out[0]
  ) else $error("filter 0 missed a matching frame in either-type mode");

  a_rsvd_sel: assert property (
    sel_all[1:0] == MSEL_RSVD |-> !hits[0]
  ) else $error("reserved selector produced a hit");

  a_sid_zeros: assert property (
    setup && rsel == REG_MSID ##1 access |-> prdata_out[4] == 1'b0 &&
    prdata_out[2] == 1'b0
  ) else $error("unimplemented mask bits read as one");

  a_sel_write: assert property (
    access && pwrite_in && rsel == REG_SELL && pstrb_in[1:0] == 2'b11
    |=> r_q.sel_lo == $past(pwdata_in[15:0])
  ) else $error("low selector register did not take the write");

  a_rsvd_silent: assert property (
    (hits & rsvd_vec) == 16'h0000
  ) else $error("a filter with the reserved selector hit");

  a_type_all: assert property (
    (hits & wrong_type) == 16'h0000
  ) else $error("a filter hit a frame of the wrong type");

  a_off_silent: assert property (
    frame_valid_in |=> (hit_vec_out & ~$past(r_q.filt_en)) == 16'h0000
  ) else $error("a disabled filter shows in the hit vector");

  a_selh_write: assert property (
    access && pwrite_in && rsel == REG_SELH && pstrb_in[1:0] == 2'b11
    |=> r_q.sel_hi == $past(pwdata_in[15:0])
  ) else $error("high selector register did not take the write");

  a_feid_write: assert property (
    access && pwrite_in && rsel == REG_FEID && pstrb_in[1:0] == 2'b11
    |=> r_q.filt_eid[$past(paddr_in[5:2])] == $past(pwdata_in[15:0])
  ) else $error("filter extension register did not take the write");

  a_msid_write: assert property (
    access && pwrite_in && rsel == REG_MSID && pstrb_in[1:0] == 2'b11
    |=> r_q.mask_sid[$past(paddr_in[3:2])] ==
        ($past(pwdata_in[15:0]) & SID_REG_IMPL)
  ) else $error("mask standard register kept an unimplemented bit");

  c_ext_accept: cover property (frame_valid_in && frame_in.ext ##1 accept_out);
  c_type_reject: cover property (frame_valid_in && |wrong_type);
  c_std_accept: cover property (frame_valid_in && !frame_in.ext ##1 accept_out);
  c_last_filter: cover property (accept_out && hit_index_out == 4'hf);
  c_bad_addr: cover property (pslverr_out);

endmodule

// [cmf_pkg.sv]
// Shared constants and types for the CAN acceptance mask filter.
// Assumes a single core clock domain and an APB register port.
package cmf_pkg;

  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;

  // Register byte offsets
  localparam logic [11:0] OFF_FILT_SID = 12'h000;
  localparam logic [11:0] OFF_FILT_EID = 12'h040;
  localparam logic [11:0] OFF_MASK_SID = 12'h080;
  localparam logic [11:0] OFF_MASK_EID = 12'h090;
  localparam logic [11:0] OFF_SEL_LO = 12'h0a0;
  localparam logic [11:0] OFF_SEL_HI = 12'h0a4;
  localparam logic [11:0] OFF_FILT_EN = 12'h0a8;
  localparam logic [11:0] OFF_STATUS = 12'h0ac;

  // Field positions in the identifier registers
  localparam int SID_MSB = 15;
  localparam int SID_LSB = 5;
  localparam int TYPE_BIT = 3;
  localparam int EIDH_MSB = 1;

  // Implemented bits and reset values
  localparam logic [15:0] SID_REG_IMPL = 16'hffeb;
  localparam logic [15:0] FULL_IMPL = 16'hffff;
  localparam logic [15:0] RST_ID = 16'h0000;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic [15:0] RST_FILT_EN = 16'hffff;

  typedef enum logic [1:0] {
    MSEL_M0 = 2'b00,
    MSEL_M1 = 2'b01,
    MSEL_M2 = 2'b10,
    MSEL_RSVD = 2'b11
  } cmf_msel_e;

  typedef enum logic [3:0] {
    REG_NONE = 4'b0000,
    REG_FSID = 4'b0001,
    REG_FEID = 4'b0010,
    REG_MSID = 4'b0011,
    REG_MEID = 4'b0100,
    REG_SELL = 4'b0101,
    REG_SELH = 4'b0110,
    REG_FEN = 4'b0111,
    REG_STAT = 4'b1000
  } cmf_reg_e;

  typedef struct packed {
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
    logic ext;
  } cmf_frame_s;

  typedef struct packed {
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
    logic filter_extended_select;
  } cmf_filt_s;

  typedef struct packed {
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
    logic frame_type_match_mode;
  } cmf_mask_s;

  typedef struct packed {
    logic [15:0][15:0] filt_sid;
    logic [15:0][15:0] filt_eid;
    logic [2:0][15:0] mask_sid;
    logic [2:0][15:0] mask_eid;
    logic [15:0] sel_lo;
    logic [15:0] sel_hi;
    logic [15:0] filt_en;
    logic [31:0] prdata;
    logic perr;
    logic accept;
    logic last_any;
    logic [3:0] hit_idx;
    logic [15:0] hit_vec;
    logic [7:0] acc_cnt;
  } cmf_state_s;

endpackage

// [cmf_match.sv]
// One acceptance filter compared against one received identifier.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module cmf_match
  import cmf_pkg::*;
(
  // Configuration
  input wire cmf_filt_s filt_in,
  input wire cmf_mask_s [NUM_MASK-1:0] masks_in,
  input wire logic [1:0] sel_in,
  input wire logic en_in,
  // Received identifier
  input wire cmf_frame_s frame_in,
  // Result
  output logic hit_out
);

  cmf_mask_s m;
  logic sel_ok;
  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  always_comb begin
    m = masks_in[0];
    sel_ok = 1'b1;
    case (cmf_msel_e'(sel_in))
      MSEL_M0: m = masks_in[0];
      MSEL_M1: m = masks_in[1];
      MSEL_M2: m = masks_in[2];
      // Reserved code never matches, so it cannot leak frames
      default: sel_ok = 1'b0;
    endcase
    // Mask one means compare, zero means don't care
    sid_ok = ((frame_in.standard_identifier_bits ^ filt_in.standard_identifier_bits) & m.standard_identifier_bits) == 11'h000;
    eid_ok = ((frame_in.extended_identifier_bits ^ filt_in.extended_identifier_bits) & m.extended_identifier_bits) == 18'h0_0000;
    type_ok = m.frame_type_match_mode ? (frame_in.ext == filt_in.filter_extended_select) : 1'b1;
    // Standard frames carry no extension bits to compare
    hit_out = en_in & sel_ok & type_ok & sid_ok & (~frame_in.ext | eid_ok);
  end

endmodule

// [cmf_prio.sv]
// Lowest-index-wins encoder over the per-filter hit vector.
// Combinational; no state.
`timescale 1ns/100ps
module cmf_prio
  import cmf_pkg::*;
(
  // Hits
  input wire logic [NUM_FILT-1:0] hits_in,
  // Winner
  output logic any_out,
  output logic [3:0] idx_out
);

  always_comb begin
    any_out = 1'b0;
    idx_out = 4'h0;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (hits_in[i]) begin
        any_out = 1'b1;
        idx_out = 4'(i);
      end
    end
  end

endmodule

// [cmf_can_node.sv]
// Remote CAN node model that hands received identifiers to the filter.
// Assumes the filter samples the identifier on the rising clock edge.
`timescale 1ns/100ps
module cmf_can_node
  import cmf_pkg::*;
(
  // Clock
  input wire logic core_clk_in,
  // Frame output
  output logic frame_valid_out,
  output cmf_frame_s frame_out
);
  initial begin
    frame_valid_out = 1'b0;
    frame_out = '0;
  end

  // Identifier inverted after the strobe so stale data cannot pass as valid
  task automatic send_frame(input cmf_frame_s f);
    @(posedge core_clk_in);
    frame_valid_out <= 1'b1;
    frame_out <= f;
    @(posedge core_clk_in);
    frame_valid_out <= 1'b0;
    frame_out <= ~f;
  endtask
endmodule

// [cmf_filter_bench.sv]
// Self-checking bench for the acceptance mask filter.
// Assumes APB with no fixed wait count and a frame strobe from the node.
`timescale 1ns/100ps
module cmf_filter_bench;
  import cmf_pkg::*;
  typedef struct packed {
    cmf_frame_s f;
    logic [15:0] vec;
  } cmf_row_s;
  localparam cmf_row_s ROWS [0:8] = '{
    '{{11'h123, 18'h0_0000, 1'b0}, 16'h0001},
    '{{11'h123, 18'h0_0000, 1'b1}, 16'h0001},
    '{{11'h123, 18'h0_0001, 1'b1}, 16'h0000},
    '{{11'h123, 18'h1_0000, 1'b1}, 16'h0000},
    '{{11'h055, 18'h0_0000, 1'b1}, 16'h0008},
    '{{11'h055, 18'h0_0000, 1'b0}, 16'h0000},
    '{{11'h7e0, 18'h0_0000, 1'b0}, 16'h0200},
    '{{11'h7ff, 18'h3_ffff, 1'b1}, 16'h0200},
    '{{11'h122, 18'h0_0000, 1'b0}, 16'h0000}};
  // Filters stay off until every used register is written
  localparam logic [11:0] CFG_A [0:16] = '{OFF_FILT_EN,
    OFF_MASK_SID, OFF_MASK_EID, 12'h084, 12'h094, 12'h088, 12'h098,
    12'h000, 12'h040, 12'h00c, 12'h04c, 12'h024, 12'h064,
    12'h03c, 12'h07c, OFF_SEL_LO, OFF_SEL_HI};
  localparam logic [15:0] CFG_D [0:16] = '{16'h0000,
    16'hfff7, 16'hffff, 16'hffe8, 16'h0000, 16'hfc00, 16'h0000,
    16'h2460, 16'h0000, 16'h0aaa, 16'habcd, 16'hffe0, 16'h0000,
    16'h2460, 16'h0000, 16'h0040, 16'hc008};
  logic core_clk_in, sys_rst_in, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, fvalid, accept;
  cmf_frame_s frame;
  logic [3:0] hidx;
  logic [15:0] hvec;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] st_rd;
  logic st_er;

  cmf_can_node i_cmf_can_node (.core_clk_in(core_clk_in),
    .frame_valid_out(fvalid), .frame_out(frame));
  cmf_filter i_cmf_filter (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .frame_valid_in(fvalid), .frame_in(frame),
    .accept_out(accept), .hit_index_out(hidx), .hit_vec_out(hvec));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Accept, vector and lowest index all derive from the expected vector
  task automatic chk_hit(input logic [15:0] ev, input string what);
    logic [3:0] ei;
    ei = 4'h0;
    for (int i = 15; i >= 0; i--) if (ev[i]) ei = i[3:0];
    cmp_count++;
    if (accept !== (|ev) || hvec !== ev || (|ev && hidx !== ei)) begin
      miscompares++;
      $display("BAD %0t %s acc %b vec %h idx %h", $time, what, accept,
        hvec, hidx);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [15:0] wd, output logic [31:0] rd, output logic er);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    @(posedge core_clk_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e,
      input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 16'h0000, rd, er);
    chk_val(rd, {16'h0000, e}, "read data");
    chk_val({31'h0, er}, {31'h0, ee}, "slave error");
  endtask

  task automatic frm(input cmf_frame_s f, input logic [15:0] ev);
    i_cmf_can_node.send_frame(f);
    #1;
    chk_hit(ev, "frame result");
    @(posedge core_clk_in);
    #1;
    chk_val({31'h0, accept}, 32'h0000_0000, "accept pulse length");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    sys_rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge core_clk_in);
    chk_hit(16'h0000, "outputs in reset");
    sys_rst_in <= 1'b0;
    rd_chk(OFF_SEL_LO, 16'h0000, 1'b0);
    rd_chk(OFF_SEL_HI, 16'h0000, 1'b0);
    rd_chk(OFF_FILT_EN, 16'hffff, 1'b0);
    rd_chk(12'h08c, 16'h0000, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 17; i++) wr(CFG_A[i], CFG_D[i]);
    wr(OFF_FILT_EN, 16'h8209);
    rd_chk(OFF_MASK_SID, 16'hffe3, 1'b0);
    rd_chk(12'h04c, 16'habcd, 1'b0);
    rd_chk(OFF_SEL_HI, 16'hc008, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      frm(ROWS[i].f, ROWS[i].vec);
    end
    $display("test frame table done");
    wr(OFF_FILT_EN, 16'h8208);
    frm(ROWS[0].f, 16'h0000);
    wr(OFF_FILT_EN, 16'h8209);
    $display("test filter disable done");
    wr(OFF_SEL_HI, 16'h0008);
    frm(ROWS[0].f, 16'h8001);
    frm(ROWS[4].f, 16'h0008);
    $display("test selector change done");
    wr(OFF_FILT_EN, 16'h8208);
    frm(ROWS[0].f, 16'h8000);
    apb(1'b0, OFF_STATUS, 16'h0000, st_rd, st_er);
    chk_val(st_rd, 32'h8000_081f, "status word");
    wr(OFF_FILT_EN, 16'h0000);
    frm(ROWS[0].f, 16'h0000);
    $display("test last filter done");
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_hit(16'h0000, "outputs in second reset");
    @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(OFF_SEL_LO, 16'h0000, 1'b0);
    rd_chk(OFF_FILT_EN, 16'hffff, 1'b0);
    wr(OFF_MASK_SID, 16'h0000);
    wr(OFF_MASK_EID, 16'h0000);
    frm(ROWS[2].f, 16'hffff);
    wr(OFF_FILT_EN, 16'h0001);
    wr(OFF_FILT_SID, 16'h0000);
    wr(OFF_MASK_SID, 16'h0008);
    frm(ROWS[1].f, 16'h0000);
    frm(ROWS[0].f, 16'h0001);
    wr(OFF_SEL_LO, 16'h0003);
    frm(ROWS[0].f, 16'h0000);
    $display("test second reset done");
    finish_test;
  end
endmodule
